// >>> hw/mam_pkg.sv
`default_nettype none
package mam_pkg;
   // ---------------------------------------------------------------
   // Program memory
   // ---------------------------------------------------------------
   localparam int          PC_WIDTH        = 13;       // Full program counter width
   localparam int          PROG_WORD_WIDTH = 14;       // Program word width
   localparam int          PROG_IMPL_WIDTH = 11;       // Implemented address bits
   localparam int          PROG_IMPL_WORDS = 2048;     // Implemented words
   localparam logic [12:0] RESET_VECTOR    = 13'h0000; // Start after reset
   localparam logic [12:0] IRQ_VECTOR      = 13'h0004; // Interrupt handler entry
   // ---------------------------------------------------------------
   // Data memory
   // ---------------------------------------------------------------
   localparam int          DATA_ADDR_WIDTH = 8;        // Banked data address width
   localparam int          DIRECT_WIDTH    = 7;        // Instruction address field
   localparam int          RAM_WORDS       = 128;      // Physical static RAM bytes
   localparam logic [7:0]  REGFILE_TOP     = 8'h1f;    // Last register location in a bank
   localparam logic [7:0]  GPR0_LO         = 8'h20;    // Bank zero RAM start
   localparam logic [7:0]  GPR0_HI         = 8'h7f;    // Bank zero RAM end
   localparam logic [7:0]  GPR1_LO         = 8'ha0;    // Bank one RAM start
   localparam logic [7:0]  GPR1_HI         = 8'hbf;    // Bank one RAM end
   localparam logic [7:0]  MIRROR_LO       = 8'hf0;    // Bank one mirror start
   localparam logic [7:0]  MIRROR_OFFSET   = 8'h80;    // Mirror maps F0h to 70h
   localparam logic [6:0]  BANK1_RAM_BASE  = 7'h60;    // Bank one RAM physical base
   localparam int          BANK_BIT_POS    = 5;        // Bank select in status
   localparam logic [7:0]  RESET_BYTE      = 8'h00;    // Reset/unmapped read value
   // Kind of a decoded data location
   typedef enum logic [1:0] {
      MAM_REGION_REGFILE,
      MAM_REGION_RAM,
      MAM_REGION_NONE
   } mam_region_type;
endpackage : mam_pkg
`default_nettype wire

// >>> hw/mam_map.sv
// Notes on behaviour
// - Thirteen-bit counter spans 8k fourteen-bit words.
// - Only words 0000h to 07FFh exist.
// - Fetches above 2k wrap by dropping bits.
// - Any reset loads counter with 0000h.
// - Accepted interrupt loads counter with 0004h.
// - Two data banks, one active for direct.
// - Lowest 32 locations per bank are registers.
// - 20h-7Fh and A0h-BFh are static RAM.
// - F0h-FFh alias 70h-7Fh in bank zero.
// - Unmapped locations read zero, ignore writes.
// - Status bit five picks the bank.
`timescale 1ns/100ps
`default_nettype none
module mam_map
   import mam_pkg::*;
(
   input  wire logic                       sys_clk,         // Core clock
   input  wire logic                       nrst,            // Synchronous reset, low
   // Program side
   input  wire logic                       pc_load,         // Load counter (jump)
   input  wire logic [mam_pkg::PC_WIDTH-1:0] pc_load_value, // Jump target
   input  wire logic                       pc_advance,      // Step to next word
   input  wire logic                       irq_accept,      // Interrupt taken
   input  wire logic                       prog_we,         // Program store write
   input  wire logic [13:0]                prog_wdata,      // Program word to store
   output logic      [mam_pkg::PC_WIDTH-1:0] pc,            // Full program counter
   output logic      [13:0]                fetch_word,      // Word at counter
   // Data side
   input  wire logic [7:0]                 status_in,       // Status register value
   input  wire logic                       data_indirect,   // Use full 8-bit address
   input  wire logic [6:0]                 data_field,      // Direct address field
   input  wire logic [7:0]                 data_ind_addr,   // Indirect address
   input  wire logic                       data_rd,         // Read request
   input  wire logic                       data_wr,         // Write request
   input  wire logic [7:0]                 data_wdata,      // Write data
   input  wire logic [7:0]                 regfile_rdata,   // Register file read data
   output logic      [7:0]                 data_rdata,      // Read result
   output logic                            regfile_sel,     // Register access strobe
   output logic                            regfile_wr,      // Register write strobe
   output logic      [7:0]                 regfile_addr,    // Register address
   output logic      [7:0]                 regfile_wdata    // Register write data
);
   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   // two-k store
   logic [13:0] prog_mem [0:PROG_IMPL_WORDS-1];  // Implemented program words
   logic [7:0]  ram      [0:RAM_WORDS-1];        // General purpose bytes

   logic [PC_WIDTH-1:0] pc_reg, pc_next;          // Program counter
   logic [13:0]         fetch_reg;                // Fetched word
   logic [7:0]          rdata_reg, rdata_next;    // Data read result
   logic                sel_reg, sel_next;        // Register strobe
   logic                wr_reg, wr_next;          // Register write strobe
   logic [7:0]          addr_reg, addr_next;      // Register address
   logic [7:0]          wdata_reg, wdata_next;    // Register write data
   logic                rd_regfile_reg;           // Last read targeted registers
   logic                rd_regfile_next;          // Next value of the above

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------
   // Classify a banked address
   function automatic mam_region_type region_of(input logic [7:0] a);
      logic [7:0] lo;
      lo = {1'b0, a[6:0]};
      if (lo <= REGFILE_TOP) begin
         region_of = MAM_REGION_REGFILE;
      end else if (a >= GPR0_LO && a <= GPR0_HI) begin
         region_of = MAM_REGION_RAM;
      end else if ((a >= GPR1_LO && a <= GPR1_HI) || a >= MIRROR_LO) begin
         region_of = MAM_REGION_RAM;
      end else begin
         region_of = MAM_REGION_NONE;
      end
   endfunction : region_of

   // Physical RAM index of a RAM address
   function automatic logic [6:0] ram_index(input logic [7:0] a);
      logic [7:0] t;
      t = 8'h00;
      if (a >= MIRROR_LO) begin
         t = a - MIRROR_OFFSET;
         ram_index = t[6:0] - GPR0_LO[6:0];
      end else if (a[7]) begin
         ram_index = BANK1_RAM_BASE + (a[6:0] - GPR1_LO[6:0]);
      end else begin
         ram_index = a[6:0] - GPR0_LO[6:0];
      end
   endfunction : ram_index

   // ---------------------------------------------------------------
   // Data address formation
   // ---------------------------------------------------------------
   logic [7:0]     eff_addr;   // Effective banked address
   mam_region_type eff_region; // Its kind
   logic [6:0]     eff_index;  // RAM index
   // Bits 7:6 of status are ignored; software keeps them zero
   // reserved bits
   always_comb begin
      eff_addr   = data_indirect ? data_ind_addr : {status_in[BANK_BIT_POS], data_field};
      eff_region = region_of(eff_addr);
      eff_index  = ram_index(eff_addr);
   end

   // ---------------------------------------------------------------
   // Program counter
   // ---------------------------------------------------------------
   // Priority: reset, interrupt, load, step
   always_comb begin
      pc_next = pc_reg;
      if (!nrst) begin
         pc_next = RESET_VECTOR;
      end else if (irq_accept) begin
         pc_next = IRQ_VECTOR;
      end else if (pc_load) begin
         pc_next = pc_load_value;
      end else if (pc_advance) begin
         pc_next = pc_reg + 13'h0001;
      end
   end

   // Counter register only; reset is already folded into pc_next
   always_ff @(posedge sys_clk) begin
      pc_reg <= pc_next;
   end

   // Store write and fetch; upper counter bits ignored
   always_ff @(posedge sys_clk) begin
      if (prog_we) begin
         prog_mem[pc_reg[PROG_IMPL_WIDTH-1:0]] <= prog_wdata;
      end
      fetch_reg <= prog_mem[pc_next[PROG_IMPL_WIDTH-1:0]];
   end

   // ---------------------------------------------------------------
   // Data access
   // ---------------------------------------------------------------
   // Compute strobes and read value for this access
   // Register reads only mark themselves here; the file answers a cycle later
   always_comb begin
      rd_regfile_next = 1'b0;
      sel_next   = 1'b0;
      wr_next    = 1'b0;
      addr_next  = addr_reg;
      wdata_next = wdata_reg;
      rdata_next = rdata_reg;
      if (!nrst) begin
         addr_next  = RESET_BYTE;
         wdata_next = RESET_BYTE;
         rdata_next = RESET_BYTE;
      end else if (data_rd || data_wr) begin
         case (eff_region)
            MAM_REGION_REGFILE: begin
               sel_next   = 1'b1;
               rd_regfile_next = data_rd;
               wr_next    = data_wr;
               addr_next  = eff_addr;
               wdata_next = data_wdata;
            end
            MAM_REGION_RAM: begin
               if (data_rd) begin
                  rdata_next = ram[eff_index];
               end
            end
            default: begin
               if (data_rd) begin
                  rdata_next = RESET_BYTE;
               end
            end
         endcase
      end
   end

   // RAM write; unmapped writes never reach storage
   always_ff @(posedge sys_clk) begin
      if (nrst && data_wr && eff_region == MAM_REGION_RAM) begin
         ram[eff_index] <= data_wdata;
      end
   end

   // Data side registers only; all decisions are made above
   always_ff @(posedge sys_clk) begin
      rdata_reg  <= rdata_next;
      sel_reg    <= sel_next;
      wr_reg     <= wr_next;
      addr_reg   <= addr_next;
      wdata_reg  <= wdata_next;
      rd_regfile_reg <= rd_regfile_next;
   end

   // ---------------------------------------------------------------
   // Output drive
   // ---------------------------------------------------------------
   // Register reads pass through from the register file one cycle on.
   // The select is a flop, but the data is the file's own answer: a
   // second flop here would make register reads a cycle slower than
   // RAM reads and two reads in a row would then collide.
   assign data_rdata    = rd_regfile_reg ? regfile_rdata : rdata_reg;
   assign pc            = pc_reg;
   assign fetch_word    = fetch_reg;
   assign regfile_sel   = sel_reg;
   assign regfile_wr    = wr_reg;
   assign regfile_addr  = addr_reg;
   assign regfile_wdata = wdata_reg;
endmodule : mam_map
`default_nettype wire

// >>> dv/mam_map_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// Map checker
// ------------------------------
module mam_chk
   import mam_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic        pc_load,
   input wire logic        pc_advance,
   input wire logic        irq_accept,
   input wire logic [12:0] pc,
   input wire logic [7:0]  status_in,
   input wire logic        data_indirect,
   input wire logic [6:0]  data_field,
   input wire logic [7:0]  data_ind_addr,
   input wire logic        data_rd,
   input wire logic        data_wr,
   input wire logic [7:0]  data_wdata,
   input wire logic [7:0]  regfile_rdata,
   input wire logic [7:0]  data_rdata,
   input wire logic        regfile_sel,
   input wire logic        regfile_wr,
   input wire logic [7:0]  regfile_addr,
   input wire logic [7:0]  regfile_wdata
);
   logic [7:0] eff; // Effective data address
   logic       acc; // Any access
   // Bank bit on top of the instruction field, or the full indirect address
   assign eff = data_indirect ? data_ind_addr : {status_in[BANK_BIT_POS], data_field};
   assign acc = data_rd | data_wr;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   property p_rst; disable iff (1'b0) !nrst |=> pc == 13'h0000; endproperty
   a_rst: assert property (p_rst) else $error("pc not cleared by reset");
   property p_irq; irq_accept |=> pc == 13'h0004; endproperty
   a_irq: assert property (p_irq) else $error("pc not at handler");
   property p_adv; pc_advance && !irq_accept && !pc_load |=> pc == $past(pc) + 13'h0001; endproperty
   a_adv: assert property (p_adv) else $error("pc step wrong");
   property p_sfr; acc && eff[6:0] < 7'h20 |=> regfile_sel && regfile_addr == $past(eff); endproperty
   a_sfr: assert property (p_sfr) else $error("register access missed");
   property p_ram; acc && eff[6:0] >= 7'h20 |=> !regfile_sel && !regfile_wr; endproperty
   a_ram: assert property (p_ram) else $error("memory access hit registers");
   property p_swr; data_wr && eff[6:0] < 7'h20 |=> regfile_wr && regfile_wdata == $past(data_wdata); endproperty
   a_swr: assert property (p_swr) else $error("register write wrong");
   // A read must select the file without writing it, and pass its answer on
   property p_srd;
      data_rd && !data_wr && eff[6:0] < 7'h20 |=> regfile_sel && !regfile_wr && data_rdata == regfile_rdata;
   endproperty
   a_srd: assert property (p_srd) else $error("register read wrong");
   property p_hole; data_rd && eff >= 8'hc0 && eff < 8'hf0 |=> data_rdata == 8'h00; endproperty
   a_hole: assert property (p_hole) else $error("unmapped read not zero");
   cover property (irq_accept);
   cover property (data_rd && eff >= 8'hf0);
   cover property (data_wr && eff == 8'hc0);
endmodule : mam_chk
bind mam_map mam_chk i_mam_chk (.sys_clk, .nrst, .pc_load, .pc_advance, .irq_accept, .pc, .status_in,
   .data_indirect, .data_field, .data_ind_addr, .data_rd, .data_wr, .data_wdata, .regfile_rdata,
   .data_rdata, .regfile_sel, .regfile_wr, .regfile_addr, .regfile_wdata);
`default_nettype wire

// >>> dv/mam_regfile_model.sv
`timescale 1ns/100ps
`default_nettype none
// Register file on the far side; unselected reads give a toggling pattern
module mam_regfile_model (
   input  wire logic       sys_clk,
   input  wire logic       regfile_sel,
   input  wire logic       regfile_wr,
   input  wire logic [7:0] regfile_addr,
   input  wire logic [7:0] regfile_wdata,
   output logic      [7:0] regfile_rdata
);
   logic [7:0] regs [0:255]; // One byte per banked location
   logic       tog = 1'b0;   // Decoy pattern source
   // Writes land on the edge that sees the strobe
   always @(posedge sys_clk) begin
      tog <= ~tog;
      if (regfile_wr) begin
         regs[regfile_addr] <= regfile_wdata;
      end
   end
   // Deselected, the bus shows a moving pattern so a stale sample shows up
   assign regfile_rdata = regfile_sel ? regs[regfile_addr] : {8{tog}};
endmodule : mam_regfile_model
`default_nettype wire

// >>> dv/mam_map_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module mam_map_tb_top;
   import mam_pkg::*;
   logic sys_clk = 0, nrst = 0, pc_load = 0, pc_advance = 0, irq_accept = 0, prog_we = 0;
   logic data_indirect = 0, data_rd = 0, data_wr = 0, regfile_sel, regfile_wr;
   logic [12:0] pc_load_value = '0, pc;
   logic [13:0] prog_wdata = '0, fetch_word;
   logic [7:0] status_in = '0, data_ind_addr = '0, data_wdata = '0;
   logic [7:0] regfile_rdata, data_rdata, regfile_addr, regfile_wdata;
   logic [6:0] data_field = '0;
   logic [7:0] ram [4] = '{8'h20, 8'h7f, 8'ha0, 8'hbf};
   int failures = 0, cmp_count = 0, cyc = 0;
   always #5 sys_clk = ~sys_clk;
   // Cut a hang short; the tests need about a hundred cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 4000) begin
         failures++;
         end_of_test();
      end
   end
   mam_map i_mam_map (.sys_clk, .nrst, .pc_load, .pc_load_value, .pc_advance, .irq_accept, .prog_we,
      .prog_wdata, .pc, .fetch_word, .status_in, .data_indirect, .data_field, .data_ind_addr, .data_rd,
      .data_wr, .data_wdata, .regfile_rdata, .data_rdata, .regfile_sel, .regfile_wr, .regfile_addr,
      .regfile_wdata);
   mam_regfile_model i_mam_regfile_model (.sys_clk, .regfile_sel, .regfile_wr, .regfile_addr,
      .regfile_wdata, .regfile_rdata);
   // Compare one value; an unknown never matches
   task check(input string what, input logic [15:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %s exp %h got %h", what, exp, got);
      end
   endtask : check
   task end_of_test;
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_of_test
   // One program-side cycle; stored word is 5 over the wrapped address
   task step(input logic ld, adv, irq, we, input logic [12:0] v);
      @(negedge sys_clk);
      {pc_load, pc_advance, irq_accept, prog_we} = {ld, adv, irq, we};
      pc_load_value = v;
      prog_wdata = {3'h5, pc[10:0]};
      @(negedge sys_clk);
      {pc_load, pc_advance, irq_accept, prog_we} = 4'h0;
   endtask : step
   // One data access; the unused address input carries a decoy
   task xf(input logic w, ind, input logic [7:0] a, d);
      @(negedge sys_clk);
      {data_wr, data_rd, data_indirect, data_wdata} = {w, !w, ind, d};
      data_ind_addr = ind ? a : ~a;
      data_field = ind ? ~a[6:0] : a[6:0];
      status_in = {2'b00, ind ^ a[7], 5'h00};
      @(negedge sys_clk);
      {data_wr, data_rd} = 2'b00;
   endtask : xf
   task t_prog;
      step(1, 0, 0, 0, 13'h0000);
      for (int i = 0; i < 8; i++) step(0, 1, 0, 1, 13'h0000);
      check("pc", pc, 13'h0008);
      step(1, 0, 0, 0, 13'h1803);
      check("pc", pc, 13'h1803);
      check("fetch", fetch_word, 14'h2803);
      step(1, 0, 1, 0, 13'h0100);
      check("pc", pc, 13'h0004);
      check("fetch", fetch_word, 14'h2804);
      step(1, 0, 0, 0, 13'h1fff);
      step(0, 1, 0, 0, 13'h0000);
      check("pc", pc, 13'h0000);
      step(1, 0, 0, 0, 13'h0007);
      nrst = 0;
      @(negedge sys_clk) nrst = 1;
      check("pc", pc, 13'h0000);
      @(negedge sys_clk);
      check("fetch", fetch_word, 14'h2800);
      $display("test prog done");
   endtask : t_prog
   task t_data;
      foreach (ram[i]) xf(1, 0, ram[i], ram[i] ^ 8'h5c);
      foreach (ram[i]) begin
         xf(0, 0, ram[i], 8'h00);
         check("ram", data_rdata, ram[i] ^ 8'h5c);
         xf(0, 1, ram[i], 8'h00);
         check("ram ind", data_rdata, ram[i] ^ 8'h5c);
      end
      xf(1, 0, 8'hf3, 8'h96);
      xf(0, 0, 8'h73, 8'h00);
      check("mirror", data_rdata, 8'h96);
      xf(1, 1, 8'h7e, 8'h69);
      xf(0, 0, 8'hfe, 8'h00);
      check("mirror", data_rdata, 8'h69);
      xf(1, 0, 8'h40, 8'h11);
      xf(1, 0, 8'hc0, 8'hff);
      xf(0, 0, 8'hc0, 8'h00);
      check("hole", data_rdata, 8'h00);
      // A dropped hole write must not have landed on the first RAM byte
      xf(0, 0, 8'h20, 8'h00);
      check("ram", data_rdata, 8'h7c);
      check("reg strobe", {regfile_sel, regfile_wr}, 2'b00);
      // Previous result is nonzero, so a stale value cannot pass
      xf(0, 1, 8'hef, 8'h00);
      check("hole", data_rdata, 8'h00);
      xf(0, 0, 8'h40, 8'h00);
      check("ram", data_rdata, 8'h11);
      xf(1, 0, 8'h03, 8'h33);
      check("reg addr", regfile_addr, 8'h03);
      check("reg data", regfile_wdata, 8'h33);
      check("reg strobe", {regfile_sel, regfile_wr}, 2'b11);
      xf(1, 0, 8'h83, 8'h44);
      check("reg addr", regfile_addr, 8'h83);
      xf(0, 0, 8'h03, 8'h00);
      check("reg read", data_rdata, 8'h33);
      check("reg strobe", {regfile_sel, regfile_wr}, 2'b10);
      xf(0, 1, 8'h83, 8'h00);
      check("reg read", data_rdata, 8'h44);
      $display("test data done");
   endtask : t_data
   initial begin
      repeat (2) @(negedge sys_clk);
      nrst = 1;
      t_prog();
      t_data();
      end_of_test();
   end
endmodule : mam_map_tb_top
`default_nettype wire
